// ===== src/adcseq_core.sv
// Summary of operation
// - Prescaler runs while enabled, held in reset while enable is low.
// - Converter clock is CPU clock divided by 2^(sel+1), sel being the divider select field.
// - Software start begins conversion on next converter clock rising edge.
// - Normal conversion lasts 13 cycles, sample-and-hold at 1.5 cycles.
// - First conversion after enable lasts 25 cycles, sample-and-hold at 14.5, unless trigger-started (then 13.5 and 2).
// - Completion stores result, sets done flag, clears start in single mode.
// - A start after completion begins on the first converter rising edge.
// - Trigger resets prescaler; sample at 2 cycles, conversion 13.5 cycles.
// - Trigger synchronisation adds three CPU clock cycles.
// - Free running restarts right after completion, start bit stays high.
// - Active selection follows buffer until conversion start, then locked.
// - Selection follows buffer again in last cycle before done is set.
// - Free-run selection change after completion applies from the conversion after next.
// - Inputs above reference give full-scale result codes.
// - Sleep entry with CPU halted starts a conversion when idle and armed.
// - Sleep-started conversion raises completion interrupt even after early wake.
// - Trigger edges ignored during conversion; held trigger does not restart.
// - Reading low result byte blocks updates until high byte is read.
// - Start bit reads one for the whole of every conversion.
`timescale 1ns/100ps
module adcseq_core #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic trigger_in,
  input wire logic sleep_idle,
  input wire logic sleep_noise_reduce,
  input wire logic cpu_halted,
  input wire logic [9:0] conv_result,
  input wire logic conv_over_range,
  output logic converter_clk,
  output logic sample_hold,
  output logic conv_active,
  output logic [4:0] active_channel,
  output logic [1:0] active_reference,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // One-hot register select, zero when unmapped
  function automatic logic [4:0] reg_decode(input logic [7:0] a);
    reg_decode = {a == adcseq_pkg::ADDR_STAT, a == adcseq_pkg::ADDR_RESH,
                  a == adcseq_pkg::ADDR_RESL, a == adcseq_pkg::ADDR_SEL,
                  a == adcseq_pkg::ADDR_CTRL};
  endfunction

  // Byte-lane mask from write strobes
  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // Control word image
  function automatic logic [31:0] ctrl_word(input adcseq_pkg::adcseq_regs_t q);
    ctrl_word = 32'h0;
    ctrl_word[adcseq_pkg::CTRL_ENABLE] = q.enable;
    ctrl_word[adcseq_pkg::CTRL_START] = q.start;
    ctrl_word[adcseq_pkg::CTRL_AUTO] = q.auto_en;
    ctrl_word[adcseq_pkg::CTRL_FREE] = q.free_run;
    ctrl_word[adcseq_pkg::CTRL_DONE] = q.done;
    ctrl_word[adcseq_pkg::CTRL_IE] = q.ie;
    ctrl_word[adcseq_pkg::CTRL_DIV_LSB +: adcseq_pkg::DIV_W] = q.div_sel;
  endfunction

  // Channel and reference word image
  function automatic logic [31:0] sel_word(input logic [4:0] ch, input logic [1:0] rf);
    sel_word = 32'h0;
    sel_word[adcseq_pkg::SEL_CH_LSB +: adcseq_pkg::CH_W] = ch;
    sel_word[adcseq_pkg::SEL_REF_LSB +: adcseq_pkg::REF_W] = rf;
  endfunction

  adcseq_pkg::adcseq_regs_t r;
  adcseq_pkg::adcseq_regs_t next_r;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic [4:0] wsel;
    logic [4:0] rsel;
    logic [31:0] wmask;
    logic [31:0] wset;
    logic [31:0] cw;
    logic [31:0] sw;
    logic [31:0] rword;
    logic [7:0] half_lim;
    logic tick;
    logic rise;
    logic trig_rise;
    logic sleep_now;
    logic sleep_go;
    logic [5:0] h;
    logic [5:0] sh_h;
    logic [5:0] end_h;
    wsel = reg_decode(r.awaddr);
    rsel = reg_decode(s_axi_araddr[7:0]);
    wmask = lane_mask(r.wstrb);
    wset = r.wdata & wmask;
    cw = (ctrl_word(r) & ~wmask) | wset;
    sw = (sel_word(r.sel_ch, r.sel_ref) & ~wmask) | wset;
    rword = 32'h0;
    half_lim = 8'h00;
    tick = 1'b0;
    rise = 1'b0;
    trig_rise = 1'b0;
    sleep_now = 1'b0;
    sleep_go = 1'b0;
    h = r.half + 6'h01;
    sh_h = r.auto_conv ? adcseq_pkg::AUTO_SH_H :
           (r.first ? adcseq_pkg::FIRST_SH_H : adcseq_pkg::NORM_SH_H);
    end_h = r.auto_conv ? adcseq_pkg::AUTO_END_H :
            (r.first ? adcseq_pkg::FIRST_END_H : adcseq_pkg::NORM_END_H);
    next_r = r;
    next_r.sample_hold = 1'b0;

    // Write address and data taken independently
    if (s_axi_awvalid && r.awready) begin
      next_r.aw_got = 1'b1;
      next_r.awaddr = s_axi_awaddr[7:0];
      next_r.awready = 1'b0;
    end
    if (s_axi_wvalid && r.wready) begin
      next_r.w_got = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
      next_r.wready = 1'b0;
    end
    if (s_axi_bready && r.bvalid) begin
      next_r.bvalid = 1'b0;
      next_r.awready = 1'b1;
      next_r.wready = 1'b1;
    end

    // Register write once both halves are held
    if (r.aw_got && r.w_got && !r.bvalid) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = (|wsel) ? adcseq_pkg::RESP_OKAY : adcseq_pkg::RESP_SLVERR;
      if (wsel[0]) begin
        next_r.enable = cw[adcseq_pkg::CTRL_ENABLE];
        next_r.auto_en = cw[adcseq_pkg::CTRL_AUTO];
        next_r.free_run = cw[adcseq_pkg::CTRL_FREE];
        next_r.ie = cw[adcseq_pkg::CTRL_IE];
        next_r.div_sel = cw[adcseq_pkg::CTRL_DIV_LSB +: adcseq_pkg::DIV_W];
        if (wset[adcseq_pkg::CTRL_START]) begin
          next_r.start = 1'b1;
        end
        if (wset[adcseq_pkg::CTRL_DONE]) begin
          next_r.done = 1'b0;
        end
      end
      if (wsel[1]) begin
        next_r.sel_ch = sw[adcseq_pkg::SEL_CH_LSB +: adcseq_pkg::CH_W];
        next_r.sel_ref = sw[adcseq_pkg::SEL_REF_LSB +: adcseq_pkg::REF_W];
      end
    end

    // Read data select
    case (1'b1)
      rsel[0]: rword = ctrl_word(r);
      rsel[1]: rword = sel_word(r.sel_ch, r.sel_ref);
      rsel[2]: rword = {24'h0, r.result[adcseq_pkg::RES_LO_W-1:0]};
      rsel[3]: rword = {30'h0, r.result[adcseq_pkg::RES_W-1:adcseq_pkg::RES_LO_W]};
      rsel[4]: rword = sel_word(r.act_ch, r.act_ref) |
                       {21'h0, r.res_lock, r.first, r.conv_active, 8'h0};
      default: rword = 32'h0;
    endcase

    // Read channel, result byte reads steer the update lock
    if (s_axi_arvalid && r.arready) begin
      next_r.arready = 1'b0;
      next_r.rvalid = 1'b1;
      next_r.rdata = rword;
      next_r.rresp = (|rsel) ? adcseq_pkg::RESP_OKAY : adcseq_pkg::RESP_SLVERR;
      if (rsel[2]) begin
        next_r.res_lock = 1'b1;
      end
      if (rsel[3]) begin
        next_r.res_lock = 1'b0;
      end
    end
    if (s_axi_rready && r.rvalid) begin
      next_r.rvalid = 1'b0;
      next_r.arready = 1'b1;
    end

    // Trigger pin through three flops, level taken when last two agree
    next_r.trig_s1 = trigger_in;
    next_r.trig_s2 = r.trig_s1;
    next_r.trig_s3 = r.trig_s2;
    trig_rise = (r.trig_s2 == r.trig_s3) && r.trig_s3 && !r.trig_level;
    if (r.trig_s2 == r.trig_s3) begin
      next_r.trig_level = r.trig_s3;
    end

    // Sleep entry with the CPU halted
    sleep_now = (sleep_idle || sleep_noise_reduce) && cpu_halted;
    next_r.sleep_prev = sleep_now;
    sleep_go = sleep_now && !r.sleep_prev && !r.auto_en && r.ie;

    // Prescaler, half period of 2^sel CPU cycles
    half_lim = (8'h01 << r.div_sel) - 8'h01;
    tick = (r.psc_cnt == half_lim);
    rise = tick && !r.psc_phase;
    if (tick) begin
      next_r.psc_cnt = 8'h00;
      next_r.psc_phase = !r.psc_phase;
    end else begin
      next_r.psc_cnt = r.psc_cnt + 8'h01;
    end

    // Active selection tracks the buffer while unlocked
    if (!r.sel_locked) begin
      next_r.act_ch = r.sel_ch;
      next_r.act_ref = r.sel_ref;
    end

    // Conversion sequencer
    if (!r.enable) begin
      next_r.psc_cnt = 8'h00;
      next_r.psc_phase = 1'b0;
      next_r.state = adcseq_pkg::ST_IDLE;
      next_r.first = 1'b1;
      // Start written together with enable is kept for the first conversion
      next_r.start = next_r.start && next_r.enable;
      next_r.sel_locked = 1'b0;
      next_r.conv_active = 1'b0;
      next_r.auto_conv = 1'b0;
      next_r.half = 6'h00;
    end else begin
      case (r.state)
        adcseq_pkg::ST_IDLE: begin
          if (r.auto_en && trig_rise) begin
            next_r.psc_cnt = 8'h00;
            next_r.psc_phase = 1'b0;
            next_r.state = adcseq_pkg::ST_CONV;
            next_r.half = 6'h00;
            next_r.auto_conv = 1'b1;
            next_r.start = 1'b1;
            next_r.sel_locked = 1'b1;
            next_r.conv_active = 1'b1;
          end else if (r.start || sleep_go) begin
            next_r.start = 1'b1;
            next_r.state = adcseq_pkg::ST_WAIT;
          end
        end
        adcseq_pkg::ST_WAIT: begin
          if (rise) begin
            next_r.state = adcseq_pkg::ST_CONV;
            next_r.half = 6'h00;
            next_r.auto_conv = 1'b0;
            next_r.sel_locked = 1'b1;
            next_r.conv_active = 1'b1;
          end
        end
        adcseq_pkg::ST_CONV: begin
          // Trigger edges are not looked at here
          if (tick) begin
            next_r.half = h;
            if (h == sh_h) begin
              next_r.sample_hold = 1'b1;
            end
            if (h == end_h - adcseq_pkg::LAST_CYCLE_H) begin
              next_r.sel_locked = 1'b0;
            end
            if (h == end_h) begin
              next_r.done = 1'b1;
              if (!r.res_lock) begin
                next_r.result = conv_over_range ? adcseq_pkg::FULL_SCALE :
                                conv_result;
              end
              next_r.first = 1'b0;
              next_r.auto_conv = 1'b0;
              if (r.auto_en && r.free_run) begin
                next_r.half = 6'h00;
                next_r.sel_locked = 1'b1;
              end else begin
                next_r.state = adcseq_pkg::ST_IDLE;
                next_r.start = 1'b0;
                next_r.conv_active = 1'b0;
              end
            end
          end
        end
        default: begin
          next_r.state = adcseq_pkg::ST_IDLE;
        end
      endcase
    end

    // Completion interrupt request
    next_r.irq = next_r.done && next_r.ie;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= adcseq_pkg::REGS_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bresp = r.bresp;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_arready = r.arready;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rvalid = r.rvalid;
  assign converter_clk = r.psc_phase;
  assign sample_hold = r.sample_hold;
  assign conv_active = r.conv_active;
  assign active_channel = r.act_ch;
  assign active_reference = r.act_ref;
  assign irq = r.irq;

endmodule

// ===== shared/adcseq_pkg.sv
package adcseq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the AXI4-Lite bus
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SEL = 8'h04;
  localparam logic [7:0] ADDR_RESL = 8'h08;
  localparam logic [7:0] ADDR_RESH = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;

  // Control and status word fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_START = 1;
  localparam int CTRL_AUTO = 2;
  localparam int CTRL_FREE = 3;
  localparam int CTRL_DONE = 4;
  localparam int CTRL_IE = 5;
  localparam int CTRL_DIV_LSB = 8;
  localparam int DIV_W = 3;

  // Channel and reference word fields
  localparam int SEL_CH_LSB = 0;
  localparam int CH_W = 5;
  localparam int SEL_REF_LSB = 6;
  localparam int REF_W = 2;

  // Status word fields above the active selection
  localparam int STAT_BUSY = 8;
  localparam int STAT_FIRST = 9;
  localparam int STAT_LOCK = 10;

  // Result layout
  localparam int RES_W = 10;
  localparam int RES_LO_W = 8;
  localparam logic [9:0] FULL_SCALE = 10'h3ff;

  ////////////////////////////////////////////////////////////////////////////
  // Timing, counted in converter clock half cycles (cycles times two)
  localparam int MIN_CPU_KHZ = 100;
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [5:0] NORM_SH_H = 6'h03;   // 1.5 cycles
  localparam logic [5:0] NORM_END_H = 6'h1a;  // 13 cycles
  localparam logic [5:0] FIRST_SH_H = 6'h1d;  // 14.5 cycles
  localparam logic [5:0] FIRST_END_H = 6'h32; // 25 cycles
  localparam logic [5:0] AUTO_SH_H = 6'h04;   // 2 cycles
  localparam logic [5:0] AUTO_END_H = 6'h1b;  // 13.5 cycles
  localparam logic [5:0] LAST_CYCLE_H = 6'h02;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_CONV = 3'b100
  } adcseq_state_t;

  typedef struct packed {
    adcseq_state_t state;
    logic enable;
    logic start;
    logic auto_en;
    logic free_run;
    logic done;
    logic ie;
    logic [2:0] div_sel;
    logic [4:0] sel_ch;
    logic [1:0] sel_ref;
    logic [4:0] act_ch;
    logic [1:0] act_ref;
    logic sel_locked;
    logic first;
    logic auto_conv;
    logic res_lock;
    logic [5:0] half;
    logic [7:0] psc_cnt;
    logic psc_phase;
    logic [9:0] result;
    logic trig_s1;
    logic trig_s2;
    logic trig_s3;
    logic trig_level;
    logic sleep_prev;
    logic sample_hold;
    logic conv_active;
    logic irq;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } adcseq_regs_t;

  localparam adcseq_regs_t REGS_RESET = '{
    state: ST_IDLE,
    first: 1'b1,
    awready: 1'b1,
    wready: 1'b1,
    arready: 1'b1,
    default: '0
  };

endpackage

// ===== sim/adcseq_props.sv
`timescale 1ns/100ps
module adcseq_props #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic converter_clk,
  input wire logic sample_hold,
  input wire logic conv_active,
  input wire logic [4:0] active_channel,
  input wire logic [1:0] active_reference
);
  // Single domain
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  // Converter side
  property p_sh_pulse; sample_hold |=> !sample_hold; endproperty
  a_sh_pulse: assert property (p_sh_pulse) else $error("sample pulse too long");
  property p_sh_conv; sample_hold |-> conv_active; endproperty
  a_sh_conv: assert property (p_sh_conv) else $error("sample outside conversion");
  property p_sh_early; $rose(conv_active) |-> !sample_hold [*2]; endproperty
  a_sh_early: assert property (p_sh_early) else $error("sample too early");
  property p_sel_lock;
    $rose(conv_active) |=> ##1 (!conv_active || $stable({active_channel, active_reference})) [*8];
  endproperty
  a_sel_lock: assert property (p_sel_lock) else $error("selection moved in conversion");
  property p_clk_half;
    conv_active && $rose(converter_clk) |-> ##[1:128] (!converter_clk || !conv_active);
  endproperty
  a_clk_half: assert property (p_clk_half) else $error("converter clock stuck high");
  property p_start_rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == adcseq_pkg::ADDR_CTRL && conv_active
      |=> s_axi_rdata[adcseq_pkg::CTRL_START];
  endproperty
  a_start_rd: assert property (p_start_rd) else $error("start bit low while busy");
  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  property p_ar_r; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_ar_r: assert property (p_ar_r) else $error("read answer late");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_b_time;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_b_time: assert property (p_b_time) else $error("write answer timing");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  // Main scenarios
  c_sample: cover property (sample_hold);
  c_done: cover property ($fell(conv_active));
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind adcseq_core adcseq_props #(.ADDR_W(ADDR_W)) adcseq_props_i (
  .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .converter_clk, .sample_hold, .conv_active, .active_channel,
  .active_reference
);

// ===== sim/adcseq_analog_model.sv
`timescale 1ns/100ps
module adcseq_analog_model (
  input wire logic aclk,
  input wire logic sample_hold,
  input wire logic conv_active,
  input wire logic [4:0] active_channel,
  input wire logic [1:0] active_reference,
  input wire logic over_req,
  output logic [9:0] conv_result,
  output logic conv_over_range
);
  logic [9:0] held;
  logic [9:0] junk = 10'h155;
  logic live = 1'b0;
  // Capture selection at the sample instant, churn the idle bus
  always @(posedge aclk) begin
    junk <= ~junk + 10'h001;
    live <= conv_active;
    if (sample_hold) begin
      held <= {active_channel, 3'h0, active_reference};
    end
  end
  // Result only valid around a conversion
  assign conv_result = (conv_active || live) ? held : junk;
  assign conv_over_range = over_req && (conv_active || live);
endmodule

// ===== sim/test_adc_conversion_sequencer.sv
`timescale 1ns/100ps
module test_adc_conversion_sequencer;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, trigger_in = 1'b0;
  logic sleep_idle = 1'b0, sleep_noise_reduce = 1'b0, cpu_halted = 1'b0, over_req = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, active_reference, r;
  logic [31:0] s_axi_rdata, d;
  logic [9:0] conv_result;
  logic conv_over_range, converter_clk, sample_hold, conv_active, irq;
  logic [4:0] active_channel;
  int err_count, samples_checked, run, conv_len, sh_at, n_done, n_sh, k;
  adcseq_core adcseq_core_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .trigger_in, .sleep_idle, .sleep_noise_reduce,
    .cpu_halted, .conv_result, .conv_over_range, .converter_clk, .sample_hold,
    .conv_active, .active_channel, .active_reference, .irq
  );
  adcseq_analog_model adcseq_analog_model_i (
    .aclk, .sample_hold, .conv_active, .active_channel, .active_reference, .over_req,
    .conv_result, .conv_over_range
  );
  // 100 MHz clock
  always #5 aclk = ~aclk;
  // Conversion length and sample position, in clocks
  always @(posedge aclk) begin
    if (sample_hold) begin
      sh_at <= run;
      n_sh <= n_sh + 1;
    end
    if (conv_active) begin
      run <= run + 1;
    end else if (run != 0) begin
      conv_len <= run;
      n_done <= n_done + 1;
      run <= 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && k < 50);
    r = s_axi_bresp;
    if (!s_axi_bvalid) err_count++;
  endtask
  // Bus read
  task automatic rd(input logic [7:0] a);
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && k < 50);
    if (!s_axi_rvalid) err_count++;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] v);
    rd(a);
    chk(d, v);
  endtask
  // Bounded waits
  task automatic wait_act;
    k = 0;
    while (conv_active !== 1'b1 && k < 300) begin
      @(posedge aclk);
      k++;
    end
    if (conv_active !== 1'b1) err_count++;
  endtask
  task automatic wait_clk(input logic lvl);
    k = 0;
    while (converter_clk === lvl && k < 300) begin
      @(posedge aclk);
      k++;
    end
  endtask
  task automatic wait_done(input int len, input int sh);
    int n0;
    n0 = n_done;
    k = 0;
    while (n_done == n0 && k < 3000) begin
      @(posedge aclk);
      k++;
    end
    if (n_done == n0) err_count++;
    chk(conv_len, len);
    chk(sh_at, sh);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    rc(8'h00, 32'h0);
    rc(8'h10, 32'h200);
    rd(8'h14);
    chk({d[31:2], r}, 32'h2);
    wr(8'h14, 32'h0);
    chk(32'(r), 32'h2);
    wait_clk(1'b0);
    chk(k, 300);
  endtask
  task automatic t_first;
    wr(8'h04, 32'h55);
    wr(8'h00, 32'h23);
    wait_done(50, 29);
    rc(8'h00, 32'h31);
    chk(32'(irq), 32'h1);
    rc(8'h08, 32'ha1);
    rc(8'h0c, 32'h2);
  endtask
  task automatic t_normal;
    wr(8'h00, 32'h33);
    rd(8'h00);
    chk(32'(d[1]), 32'h1);
    wr(8'h04, 32'h9f);
    wait_done(26, 3);
    rc(8'h08, 32'ha1);
    rc(8'h0c, 32'h2);
    rc(8'h10, 32'h9f);
  endtask
  task automatic t_lock;
    rc(8'h08, 32'ha1);
    wr(8'h00, 32'h33); // Result after reference switch goes unused
    wait_done(26, 3);
    rc(8'h10, 32'h49f);
    rc(8'h0c, 32'h2);
    rc(8'h00, 32'h31);
    chk(32'(irq), 32'h1);
  endtask
  task automatic t_over;
    over_req <= 1'b1;
    wr(8'h00, 32'h33);
    wait_done(26, 3);
    rc(8'h08, 32'hff);
    rc(8'h0c, 32'h3);
    over_req <= 1'b0;
    wr(8'h00, 32'h13);
    wait_done(26, 3);
    rc(8'h00, 32'h11);
    chk(32'(irq), 32'h0);
    wr(8'h00, 32'h21);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h1);
  endtask
  task automatic t_auto;
    int n0;
    wr(8'h00, 32'h35); // Selection left alone while armed
    n0 = n_sh;
    trigger_in <= 1'b1;
    wait_act;
    chk(32'(k >= 3 && k <= 6), 32'h1);
    repeat (6) @(posedge aclk);
    trigger_in <= 1'b0;
    repeat (2) @(posedge aclk);
    trigger_in <= 1'b1;
    wait_done(27, 4);
    repeat (40) @(posedge aclk);
    chk(n_sh - n0, 32'h1);
    chk(32'(conv_active), 32'h0);
    trigger_in <= 1'b0;
    wr(8'h00, 32'h21);
  endtask
  task automatic t_free;
    int n0, lo;
    wr(8'h00, 32'h3f);
    wait_act;
    n0 = n_sh;
    lo = 0;
    while (n_sh < n0 + 3 && lo < 400) begin
      @(posedge aclk);
      lo += (conv_active !== 1'b1) ? 1 : 0;
    end
    chk(lo, 32'h0);
    rd(8'h00);
    chk(32'(d[1]), 32'h1);
    wr(8'h00, 32'h31);
    wait_clk(1'b1);
    wait_clk(1'b0);
    repeat (60) @(posedge aclk);
  endtask
  task automatic t_sleep;
    for (int m = 0; m < 2; m++) begin
      wr(8'h00, 32'h31);
      sleep_idle <= (m == 0); // Only the sleep states that keep converting
      sleep_noise_reduce <= (m == 1);
      cpu_halted <= 1'b1;
      wait_act;
      cpu_halted <= 1'b0;
      sleep_idle <= 1'b0;
      sleep_noise_reduce <= 1'b0;
      wait_done(26, 3);
      @(posedge aclk);
      chk(32'(irq), 32'h1);
    end
  endtask
  task automatic t_div;
    for (int dv = 1; dv < 4; dv++) begin
      wr(8'h00, 32'h0);
      wr(8'h00, 32'h1 | (dv << 8)); // Fast clock, reduced resolution accepted
      wait_clk(1'b1);
      wait_clk(1'b0);
      wait_clk(1'b1);
      chk(k, 1 << dv);
    end
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h203);
    wait_done(200, 116);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Verdict
  task automatic results;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #500000;
    err_count++;
    results();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_first();
    t_normal();
    t_lock();
    t_over();
    t_auto();
    t_free();
    t_sleep();
    t_div();
    results();
  end
endmodule
